// [rcts_sequencer.sv]
// RC temperature port sequencer: dummy, evaluate and real port cycles
// ----------------------------------------------------------------
// Functional notes
// - Time RC discharge on sensor ports; charge capacitor via own driver before each.
// - Run zero to seven dummy preamble cycles, count from three-bit field.
// - Dummy cycles discharge through internal emulation resistor, not thermistor.
// - Insert coarse evaluate before each real measurement; it sets converter range.
// - Start-to-start interval between port measurements chosen by two-bit field.
// - At end store results, set done flag, assert active-low interrupt if enabled.
// - Measured time under 8 us means shorted probe; result is 0000h.
// - No discharge within 2 us past interval: open probe, FFFFh, flag, interrupt.
// - Any other failure writes FFFFh to every port result.
// ----------------------------------------------------------------
`timescale 1ns/1ps

module rcts_sequencer
#(
  parameter int PORT_UNIT_US = rcts_pkg::PORT_UNIT_US,
  parameter int CHARGE_US    = rcts_pkg::CHARGE_US,
  parameter int CNT_W        = 16
)
(
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_IN,
  input  wire logic        START_IN,
  input  wire logic [2:0]  PREAMBLE_CYCLE_COUNT_IN,
  input  wire logic [1:0]  PORT_CYCLE_INTERVAL_IN,
  input  wire logic        INT_ENABLE_IN,
  input  wire logic        CLEAR_FLAGS_IN,
  input  wire logic        FAULT_IN,
  input  wire logic        CMP_ABOVE_IN,
  output logic             CAP_CHARGE_PIN_OUT,
  output logic             EMUL_SEL_OUT,
  output logic             SENSOR_PORT_A_SEL_OUT,
  output logic             SENSOR_PORT_B_SEL_OUT,
  output logic             COARSE_EVALUATE_CYCLE_OUT,
  output logic [1:0]       CONV_RANGE_OUT,
  output logic             BUSY_OUT,
  output logic [15:0]      PORT_A_TIME_INTEGER_RESULT_OUT,
  output logic [15:0]      PORT_A_TIME_FRACTION_RESULT_OUT,
  output logic [15:0]      PORT_B_TIME_INTEGER_RESULT_OUT,
  output logic [15:0]      PORT_B_TIME_FRACTION_RESULT_OUT,
  output logic             TEMP_DONE_FLAG_OUT,
  output logic             PROBE_OPEN_FLAG_OUT,
  output logic             INT_N_OUT
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rcts_pkg::rcts_state_t state_r, state_nxt;
  rcts_pkg::rcts_kind_t  kind_r, kind_nxt;
  logic                  port_r, port_nxt;
  logic [2:0]            dummy_r, dummy_nxt;
  logic [1:0]            pcyc_r, pcyc_nxt;
  logic [CNT_W-1:0]      slot_r, slot_nxt;
  logic [15:0]           us_r, us_nxt;
  logic [5:0]            sub_r, sub_nxt;
  logic [1:0]            range_r, range_nxt;
  logic [15:0]           tint_r [2];
  logic [15:0]           tint_nxt [2];
  logic [15:0]           tfrac_r [2];
  logic [15:0]           tfrac_nxt [2];
  logic [15:0]           oint_r [2];
  logic [15:0]           oint_nxt [2];
  logic [15:0]           ofrac_r [2];
  logic [15:0]           ofrac_nxt [2];
  logic                  done_r, done_nxt;
  logic                  open_r, open_nxt;
  logic                  intn_r, intn_nxt;
  logic                  drv_r, drv_nxt;
  logic                  emul_r, emul_nxt;
  logic                  pa_r, pa_nxt;
  logic                  pb_r, pb_nxt;
  logic                  eval_r, eval_nxt;
  logic                  busy_r, busy_nxt;
  logic                  cmp_above;
  logic                  set_open;

  // Charge time follows the timing capacitor in use; it must fit inside the shortest slot
  localparam int CHARGE_CYC = CHARGE_US * rcts_pkg::CLK_MHZ;

  rcts_pin_sync u_cmp_sync
  (
    .CLOCK_IN  (CLOCK_IN),
    .RST_IN    (RST_IN),
    .pin_in    (CMP_ABOVE_IN),
    .level_out (cmp_above)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] interval_cyc(input logic [1:0] sel);
    interval_cyc = CNT_W'((int'(sel) + 1) * PORT_UNIT_US * rcts_pkg::CLK_MHZ);
  endfunction

  // Coarse time picks the converter range for the real cycle
  function automatic logic [1:0] coarse_range(input logic [15:0] us);
    if (us >= rcts_pkg::RANGE_T3)
      coarse_range = 2'h3;
    else if (us >= rcts_pkg::RANGE_T2)
      coarse_range = 2'h2;
    else if (us >= rcts_pkg::RANGE_T1)
      coarse_range = 2'h1;
    else
      coarse_range = 2'h0;
  endfunction

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    port_nxt  = port_r;
    dummy_nxt = dummy_r;
    pcyc_nxt  = pcyc_r;
    slot_nxt  = slot_r;
    us_nxt    = us_r;
    sub_nxt   = sub_r;
    range_nxt = range_r;
    tint_nxt  = tint_r;
    tfrac_nxt = tfrac_r;
    oint_nxt  = oint_r;
    ofrac_nxt = ofrac_r;
    set_open  = 1'b0;
    done_nxt  = done_r;
    unique case (state_r)
      rcts_pkg::ST_IDLE:
      begin
        if (START_IN)
        begin
          // Field values are latched so a mid-run change has no effect
          pcyc_nxt  = PORT_CYCLE_INTERVAL_IN;
          dummy_nxt = PREAMBLE_CYCLE_COUNT_IN;
          port_nxt  = 1'b0;
          slot_nxt  = '0;
          kind_nxt  = (PREAMBLE_CYCLE_COUNT_IN != 3'h0) ? rcts_pkg::K_DUMMY
                                                       : rcts_pkg::K_EVAL;
          state_nxt = rcts_pkg::ST_CHARGE;
        end
      end
      rcts_pkg::ST_CHARGE:
      begin
        slot_nxt = slot_r + 1'b1;
        if (slot_r == CNT_W'(CHARGE_CYC - 1))
        begin
          us_nxt    = '0;
          sub_nxt   = '0;
          state_nxt = rcts_pkg::ST_DISCHARGE;
        end
      end
      rcts_pkg::ST_DISCHARGE:
      begin
        slot_nxt = slot_r + 1'b1;
        sub_nxt  = (sub_r == rcts_pkg::SUB_LAST) ? 6'h00 : sub_r + 1'b1;
        us_nxt   = (sub_r == rcts_pkg::SUB_LAST) ? us_r + 1'b1 : us_r;
        if (!cmp_above)
        begin
          state_nxt = rcts_pkg::ST_SETTLE;
          if (kind_r == rcts_pkg::K_EVAL)
            range_nxt = coarse_range(us_r);
          else if (kind_r == rcts_pkg::K_REAL)
          begin
            if (us_r < 16'(rcts_pkg::SHORT_US))
            begin
              tint_nxt[port_r]  = rcts_pkg::RES_SHORT;
              tfrac_nxt[port_r] = rcts_pkg::RES_SHORT;
            end
            else
            begin
              tint_nxt[port_r]  = us_r;
              tfrac_nxt[port_r] = 16'(sub_r * rcts_pkg::FRAC_STEP);
            end
          end
        end
        else if (slot_r >= interval_cyc(pcyc_r) + CNT_W'(rcts_pkg::OPEN_GRACE_CYC))
        begin
          state_nxt = rcts_pkg::ST_SETTLE;
          if (kind_r == rcts_pkg::K_DUMMY)
          begin
            // A stuck internal path is not a probe fault: whole run is void
            tint_nxt  = '{rcts_pkg::RES_OPEN, rcts_pkg::RES_OPEN};
            tfrac_nxt = '{rcts_pkg::RES_OPEN, rcts_pkg::RES_OPEN};
            state_nxt = rcts_pkg::ST_STORE;
          end
          else
          begin
            set_open          = 1'b1;
            tint_nxt[port_r]  = rcts_pkg::RES_OPEN;
            tfrac_nxt[port_r] = rcts_pkg::RES_OPEN;
            kind_nxt          = rcts_pkg::K_REAL; // skip the real cycle of this port
          end
        end
      end
      rcts_pkg::ST_SETTLE:
      begin
        slot_nxt = slot_r + 1'b1;
        if (slot_r >= interval_cyc(pcyc_r) - 1'b1)
        begin
          slot_nxt  = '0;
          state_nxt = rcts_pkg::ST_CHARGE;
          unique case (kind_r)
            rcts_pkg::K_DUMMY:
            begin
              dummy_nxt = dummy_r - 1'b1;
              if (dummy_r == 3'h1)
                kind_nxt = rcts_pkg::K_EVAL;
            end
            rcts_pkg::K_EVAL:
              kind_nxt = rcts_pkg::K_REAL;
            default:
            begin
              if (port_r)
                state_nxt = rcts_pkg::ST_STORE;
              else
              begin
                port_nxt = 1'b1;
                kind_nxt = rcts_pkg::K_EVAL;
              end
            end
          endcase
        end
      end
      rcts_pkg::ST_STORE:
      begin
        oint_nxt  = tint_r;
        ofrac_nxt = tfrac_r;
        done_nxt  = 1'b1;
        state_nxt = rcts_pkg::ST_IDLE;
      end
      default:
        state_nxt = rcts_pkg::ST_IDLE;
    endcase
    if (FAULT_IN && state_r != rcts_pkg::ST_IDLE && state_r != rcts_pkg::ST_STORE)
    begin
      tint_nxt  = '{rcts_pkg::RES_OPEN, rcts_pkg::RES_OPEN};
      tfrac_nxt = '{rcts_pkg::RES_OPEN, rcts_pkg::RES_OPEN};
      set_open  = 1'b0;
      state_nxt = rcts_pkg::ST_STORE;
    end
    // Set wins over a clear in the same cycle
    if (CLEAR_FLAGS_IN && state_r != rcts_pkg::ST_STORE)
      done_nxt = 1'b0;
    open_nxt  = set_open | (open_r & ~CLEAR_FLAGS_IN);
    intn_nxt  = ~(INT_ENABLE_IN & (done_nxt | open_nxt));
    drv_nxt   = (state_nxt == rcts_pkg::ST_CHARGE);
    emul_nxt  = (state_nxt == rcts_pkg::ST_DISCHARGE) && (kind_nxt == rcts_pkg::K_DUMMY);
    pa_nxt    = (state_nxt == rcts_pkg::ST_DISCHARGE) && (kind_nxt != rcts_pkg::K_DUMMY)
                && !port_nxt;
    pb_nxt    = (state_nxt == rcts_pkg::ST_DISCHARGE) && (kind_nxt != rcts_pkg::K_DUMMY)
                && port_nxt;
    eval_nxt  = (state_nxt != rcts_pkg::ST_IDLE) && (kind_nxt == rcts_pkg::K_EVAL);
    busy_nxt  = (state_nxt != rcts_pkg::ST_IDLE);
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
    begin
      state_r <= rcts_pkg::ST_IDLE;
      kind_r  <= rcts_pkg::K_DUMMY;
      port_r  <= 1'b0;
      dummy_r <= 3'h0;
      pcyc_r  <= 2'h0;
      slot_r  <= '0;
      us_r    <= 16'h0000;
      sub_r   <= 6'h00;
      range_r <= 2'h0;
      tint_r  <= '{16'h0000, 16'h0000};
      tfrac_r <= '{16'h0000, 16'h0000};
      oint_r  <= '{16'h0000, 16'h0000};
      ofrac_r <= '{16'h0000, 16'h0000};
      done_r  <= 1'b0;
      open_r  <= 1'b0;
      intn_r  <= 1'b1;
      drv_r   <= 1'b0;
      emul_r  <= 1'b0;
      pa_r    <= 1'b0;
      pb_r    <= 1'b0;
      eval_r  <= 1'b0;
      busy_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
      port_r  <= port_nxt;
      dummy_r <= dummy_nxt;
      pcyc_r  <= pcyc_nxt;
      slot_r  <= slot_nxt;
      us_r    <= us_nxt;
      sub_r   <= sub_nxt;
      range_r <= range_nxt;
      tint_r  <= tint_nxt;
      tfrac_r <= tfrac_nxt;
      oint_r  <= oint_nxt;
      ofrac_r <= ofrac_nxt;
      done_r  <= done_nxt;
      open_r  <= open_nxt;
      intn_r  <= intn_nxt;
      drv_r   <= drv_nxt;
      emul_r  <= emul_nxt;
      pa_r    <= pa_nxt;
      pb_r    <= pb_nxt;
      eval_r  <= eval_nxt;
      busy_r  <= busy_nxt;
    end
  end

  assign CAP_CHARGE_PIN_OUT              = drv_r;
  assign EMUL_SEL_OUT                    = emul_r;
  assign SENSOR_PORT_A_SEL_OUT           = pa_r;
  assign SENSOR_PORT_B_SEL_OUT           = pb_r;
  assign COARSE_EVALUATE_CYCLE_OUT       = eval_r;
  assign CONV_RANGE_OUT                  = range_r;
  assign BUSY_OUT                        = busy_r;
  assign PORT_A_TIME_INTEGER_RESULT_OUT  = oint_r[0];
  assign PORT_A_TIME_FRACTION_RESULT_OUT = ofrac_r[0];
  assign PORT_B_TIME_INTEGER_RESULT_OUT  = oint_r[1];
  assign PORT_B_TIME_FRACTION_RESULT_OUT = ofrac_r[1];
  assign TEMP_DONE_FLAG_OUT              = done_r;
  assign PROBE_OPEN_FLAG_OUT             = open_r;
  assign INT_N_OUT                       = intn_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  chk_charge_first: assert property (
    state_r == rcts_pkg::ST_DISCHARGE && $past(state_r) != rcts_pkg::ST_DISCHARGE
    |-> $past(state_r) == rcts_pkg::ST_CHARGE && $past(drv_r))
    else $error("discharge began without a charge phase");
  chk_no_preamble: assert property (
    state_r == rcts_pkg::ST_IDLE && START_IN && PREAMBLE_CYCLE_COUNT_IN == 3'h0
    |=> kind_r == rcts_pkg::K_EVAL ##1 drv_r && !emul_r)
    else $error("zero preamble count still ran a dummy cycle");
  chk_emul_path: assert property (
    emul_r |-> kind_r == rcts_pkg::K_DUMMY && !pa_r && !pb_r)
    else $error("emulation path selected outside a dummy cycle");
  chk_eval_first: assert property (
    kind_r == rcts_pkg::K_REAL && $past(kind_r) != rcts_pkg::K_REAL
    |-> $past(kind_r) == rcts_pkg::K_EVAL)
    else $error("real cycle not preceded by evaluate");
  chk_slot_spacing: assert property (
    state_r == rcts_pkg::ST_CHARGE && $past(state_r) == rcts_pkg::ST_SETTLE
    |-> $past(slot_r) >= interval_cyc(pcyc_r) - 1'b1 && slot_r == '0)
    else $error("next cycle started before its interval");
  chk_done_int: assert property (
    state_r == rcts_pkg::ST_STORE && INT_ENABLE_IN
    |=> done_r && !intn_r && busy_r == 1'b0 && oint_r[0] == $past(tint_r[0])
        && oint_r[1] == $past(tint_r[1]))
    else $error("completion did not store results and interrupt");
  chk_short_zero: assert property (
    state_r == rcts_pkg::ST_DISCHARGE && !cmp_above && kind_r == rcts_pkg::K_REAL
    && us_r < 16'(rcts_pkg::SHORT_US) && !FAULT_IN
    |=> tint_r[port_r] == rcts_pkg::RES_SHORT && tfrac_r[port_r] == rcts_pkg::RES_SHORT)
    else $error("short probe not recorded as zero");
  chk_open_flag: assert property (
    set_open |=> open_r && tint_r[$past(port_r)] == rcts_pkg::RES_OPEN)
    else $error("open probe not flagged");
  chk_fault_all: assert property (
    FAULT_IN && busy_r && state_r != rcts_pkg::ST_STORE
    |=> state_r == rcts_pkg::ST_STORE && tint_r[0] == rcts_pkg::RES_OPEN
        && tint_r[1] == rcts_pkg::RES_OPEN ##1 oint_r[1] == rcts_pkg::RES_OPEN)
    else $error("fault did not void all port results");
  chk_store_last: assert property (
    state_r == rcts_pkg::ST_STORE && !$past(FAULT_IN) && $past(state_r) == rcts_pkg::ST_SETTLE
    |-> port_r && kind_r == rcts_pkg::K_REAL)
    else $error("results stored before the last port");

  cov_full_pre: cover property (START_IN && PREAMBLE_CYCLE_COUNT_IN == 3'h7 && !busy_r);
  cov_open: cover property (set_open);
  cov_short: cover property (state_r == rcts_pkg::ST_DISCHARGE && !cmp_above
                             && kind_r == rcts_pkg::K_REAL && us_r < 16'h0008);
  cov_done: cover property (state_r == rcts_pkg::ST_STORE && !FAULT_IN);
endmodule

// [rcts_pin_sync.sv]
// Sequencer constants and the comparator pin synchroniser
`timescale 1ns/1ps

package rcts_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ        = 40;
  localparam int          CHARGE_US      = 32;
  localparam int          CHARGE_CYC     = CHARGE_US * CLK_MHZ;
  localparam int          SHORT_US       = 8;
  localparam int          OPEN_GRACE_US  = 2;
  localparam int          OPEN_GRACE_CYC = OPEN_GRACE_US * CLK_MHZ;
  localparam int          PORT_UNIT_US   = 128;
  // ----------------------------------------------------------------
  // Field widths, result codes, fraction step and range thresholds
  // ----------------------------------------------------------------
  localparam int          PRE_W          = 3;
  localparam int          PCYC_W         = 2;
  localparam int          SUB_W          = 6;
  localparam int          RES_W          = 16;
  localparam logic [15:0] RES_SHORT      = 16'h0000;
  localparam logic [15:0] RES_OPEN       = 16'hFFFF;
  localparam logic [15:0] FRAC_STEP      = 16'h0666;
  localparam logic [5:0]  SUB_LAST       = 6'h27;
  localparam logic [15:0] RANGE_T1       = 16'h0010;
  localparam logic [15:0] RANGE_T2       = 16'h0020;
  localparam logic [15:0] RANGE_T3       = 16'h0040;

  typedef enum logic [2:0] {ST_IDLE, ST_CHARGE, ST_DISCHARGE, ST_SETTLE, ST_STORE} rcts_state_t;
  typedef enum logic [1:0] {K_DUMMY, K_EVAL, K_REAL} rcts_kind_t;
endpackage

module rcts_pin_sync
(
  input  wire logic CLOCK_IN,
  input  wire logic RST_IN,
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic level_nxt;

  // A change counts only once stages two and three agree
  always_comb
  begin
    level_nxt = (s2_r == s3_r) ? s3_r : level_r;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
    begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end
    else
    begin
      s1_r    <= pin_in;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r;
endmodule

// [rcts_rc_model.sv]
// Behavioural RC network seen from the sequencer: resistors, capacitor, comparator
`timescale 1ns/1ps

module rcts_rc_model
(
  input  wire logic        clk_in,
  input  wire logic        charge_in,
  input  wire logic        emul_sel_in,
  input  wire logic        port_a_sel_in,
  input  wire logic        port_b_sel_in,
  input  wire logic [15:0] emul_cyc_in,
  input  wire logic [15:0] port_a_cyc_in,
  input  wire logic [15:0] port_b_cyc_in,
  output logic             cmp_above_out
);
  logic [15:0] cnt_r = 16'h0000;
  logic [15:0] lim;

  // Zero limit models a broken lead: the capacitor never discharges
  assign lim = emul_sel_in ? emul_cyc_in : (port_a_sel_in ? port_a_cyc_in : port_b_cyc_in);
  initial cmp_above_out = 1'b0;

  always @(posedge clk_in)
  begin
    if (charge_in)
    begin
      cmp_above_out <= 1'b1;
      cnt_r         <= 16'h0000;
    end
    else if (emul_sel_in | port_a_sel_in | port_b_sel_in)
    begin
      cnt_r <= cnt_r + 16'h0001;
      if (lim != 16'h0000 && cnt_r + 16'h0001 >= lim)
        cmp_above_out <= 1'b0;
    end
  end
endmodule

// [rcts_sequencer_tb_top.sv]
// Self-checking bench for the RC temperature port sequencer
`timescale 1ns/1ps

module rcts_sequencer_tb_top;
  // Short port unit and charge keep slots brief; a slot must still hold charge and discharge
  localparam int UNIT   = 8;
  localparam int CHG_US = 4;
  localparam int UCYC   = UNIT * rcts_pkg::CLK_MHZ;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic [2:0]  pre = 3'h0;
  logic [1:0]  pcyc = 2'h0;
  logic        int_en = 1'b0;
  logic        clr = 1'b0;
  logic        fault = 1'b0;
  logic [15:0] d_emul = 16'h0032;
  logic [15:0] d_a = 16'h0000;
  logic [15:0] d_b = 16'h0000;
  logic        cmp, chg, emul, sel_a, sel_b, coarse, busy, done, open_f, int_n;
  logic [1:0]  range;
  logic [15:0] a_int, a_frac, b_int, b_frac;
  logic        chg_d = 1'b0, e_d = 1'b0, a_d = 1'b0, b_d = 1'b0;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;
  int          ev_q[$];
  int          rise_q[$];
  logic [1:0]  rng_q[$];

  always #12.5 clock = ~clock;

  rcts_sequencer #(.PORT_UNIT_US(UNIT), .CHARGE_US(CHG_US))
    DUT (.CLOCK_IN(clock), .RST_IN(rst), .START_IN(start),
    .PREAMBLE_CYCLE_COUNT_IN(pre), .PORT_CYCLE_INTERVAL_IN(pcyc), .INT_ENABLE_IN(int_en),
    .CLEAR_FLAGS_IN(clr), .FAULT_IN(fault), .CMP_ABOVE_IN(cmp), .CAP_CHARGE_PIN_OUT(chg),
    .EMUL_SEL_OUT(emul), .SENSOR_PORT_A_SEL_OUT(sel_a), .SENSOR_PORT_B_SEL_OUT(sel_b),
    .COARSE_EVALUATE_CYCLE_OUT(coarse), .CONV_RANGE_OUT(range), .BUSY_OUT(busy),
    .PORT_A_TIME_INTEGER_RESULT_OUT(a_int), .PORT_A_TIME_FRACTION_RESULT_OUT(a_frac),
    .PORT_B_TIME_INTEGER_RESULT_OUT(b_int), .PORT_B_TIME_FRACTION_RESULT_OUT(b_frac),
    .TEMP_DONE_FLAG_OUT(done), .PROBE_OPEN_FLAG_OUT(open_f), .INT_N_OUT(int_n));

  rcts_rc_model RC (.clk_in(clock), .charge_in(chg), .emul_sel_in(emul), .port_a_sel_in(sel_a),
    .port_b_sel_in(sel_b), .emul_cyc_in(d_emul), .port_a_cyc_in(d_a), .port_b_cyc_in(d_b),
    .cmp_above_out(cmp));

  // ----------------------------------------------------------------
  // Phase monitor: 0 dummy, 1/2 port A eval/real, 3/4 port B, 9 overlap
  // ----------------------------------------------------------------
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    chg_d <= chg;
    e_d <= emul;
    a_d <= sel_a;
    b_d <= sel_b;
    if (chg && !chg_d)
      rise_q.push_back(cyc);
    if (emul && !e_d)
      ev_q.push_back(chg ? 9 : 0);
    if (sel_a && !a_d)
      ev_q.push_back(chg ? 9 : (coarse ? 1 : 2));
    if (sel_b && !b_d)
      ev_q.push_back(chg ? 9 : (coarse ? 3 : 4));
    if (((sel_a && !a_d) || (sel_b && !b_d)) && !coarse)
      rng_q.push_back(range);
  end

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    check16({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One run; at cycle poke_at a fault or a second start is pulsed
  task automatic run(input logic [2:0] p, input logic [1:0] s, input logic en,
                     input int poke_at, input bit poke_fault);
    int n;
    @(negedge clock);
    pre = p;
    pcyc = s;
    int_en = en;
    clr = 1'b1;
    @(negedge clock);
    clr = 1'b0;
    check1(done, 1'b0);
    check1(open_f, 1'b0);
    start = 1'b1;
    ev_q.delete();
    rise_q.delete();
    rng_q.delete();
    @(negedge clock);
    start = 1'b0;
    n = 0;
    while (busy === 1'b1 && n < 40000)
    begin
      @(negedge clock);
      n++;
      fault = (n == poke_at) && poke_fault;
      start = (n == poke_at) && !poke_fault;
    end
    check1(busy, 1'b0);
    @(negedge clock);
  endtask

  task automatic test_normal();
    d_a = 16'h019A;
    d_b = 16'h02A8;
    run(3'h7, 2'h3, 1'b1, 3000, 1'b0);
    check16(16'(ev_q.size()), 16'h000B);
    check16(16'(rise_q.size()), 16'h000B);
    for (int i = 0; i < ev_q.size(); i++)
      check16(16'(ev_q[i]), (i < 7) ? 16'h0000 : 16'(i - 6));
    check16(16'(rng_q.size()), 16'h0002);
    if (rng_q.size() == 2)
    begin
      check16({14'h0000, rng_q[0]}, 16'h0000);
      check16({14'h0000, rng_q[1]}, 16'h0001);
    end
    check16(a_int, 16'h000A);
    check16(b_int, 16'h0011);
    check1(done, 1'b1);
    check1(int_n, 1'b0);
    check1(open_f, 1'b0);
    $display("normal run finished");
  endtask

  task automatic test_intervals();
    d_a = 16'h0064;
    d_b = 16'h0064;
    for (int s = 0; s < 4; s++)
    begin
      run(3'h0, 2'(s), 1'b0, 0, 1'b0);
      check16(16'(ev_q.size()), 16'h0004);
      if (rise_q.size() > 1)
        check16(16'(rise_q[1] - rise_q[0]), 16'((s + 1) * UCYC));
      check16(a_int, rcts_pkg::RES_SHORT);
      check16(a_frac, rcts_pkg::RES_SHORT);
      check16(b_int, rcts_pkg::RES_SHORT);
      check16(b_frac, rcts_pkg::RES_SHORT);
      check1(int_n, 1'b1);
    end
    $display("interval and short probe runs finished");
  endtask

  task automatic test_open();
    d_a = 16'h0000;
    d_b = 16'h0168;
    run(3'h0, 2'h1, 1'b1, 0, 1'b0);
    check16(a_int, rcts_pkg::RES_OPEN);
    check16(a_frac, rcts_pkg::RES_OPEN);
    check16(b_int, 16'h0009);
    check1(open_f, 1'b1);
    check1(int_n, 1'b0);
    check16(16'(ev_q.size()), 16'h0003);
    $display("open probe run finished");
  endtask

  task automatic test_fault();
    d_a = 16'h019A;
    d_b = 16'h02A8;
    run(3'h2, 2'h3, 1'b0, 2000, 1'b1);
    check16(a_int, rcts_pkg::RES_OPEN);
    check16(a_frac, rcts_pkg::RES_OPEN);
    check16(b_int, rcts_pkg::RES_OPEN);
    check16(b_frac, rcts_pkg::RES_OPEN);
    check1(done, 1'b1);
    check1(int_n, 1'b1);
    $display("fault abort run finished");
  endtask

  initial
  begin
    repeat (16) @(negedge clock);
    rst = 1'b0;
    test_normal();
    test_intervals();
    test_open();
    test_fault();
    wrap_up();
  end

  // Whole run is near 31000 cycles; 60000 means a hang
  initial
  begin
    #(60000 * 25);
    n_mismatch++;
    wrap_up();
  end
endmodule
